//--- bench/system_watchdog_timer_tb.sv
module system_watchdog_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned N = 10;

   typedef struct {
      logic [7:0] idx;
      logic [7:0] wdata;
      logic [7:0] exp;
   } row_s;

   logic       mclk_i;
   logic       reset_n_i;
   logic       io_wr_i;
   logic       io_rd_i;
   logic [7:0] io_addr_i;
   logic [7:0] io_wdata_i;
   logic [7:0] io_rdata_o;
   logic       sys_reset_o;
   logic [7:0] rd;
   int         failures   = 0;
   int         n_compared = 0;
   int         pulses     = 0;
   int         n;

   // Enable stays off through the table, so the preset readback is not a live count
   row_s rows [6] = '{'{8'h07, 8'h08, 8'h08}, '{8'h30, 8'h00, 8'h00},
                      '{8'hf0, 8'h08, 8'h08}, '{8'hf0, 8'h00, 8'h00},
                      '{8'hf1, 8'h05, 8'h05}, '{8'h40, 8'h12, 8'hff}};

   system_watchdog_timer #(.SEC_CYCLES(N)) i_dut (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .io_wr_i     (io_wr_i),
      .io_rd_i     (io_rd_i),
      .io_addr_i   (io_addr_i),
      .io_wdata_i  (io_wdata_i),
      .io_rdata_o  (io_rdata_o),
      .sys_reset_o (sys_reset_o)
   );

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   // Counts every cycle the reset request is high, so stray pulses show up later
   always @(posedge mclk_i) begin
      if (sys_reset_o === 1'b1) pulses <= pulses + 1;
   end

   task automatic close_out;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chkn(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("unexpected at %0t: cycles %0d, wanted %0d", $time, got, exp);
      end
   endtask : chkn

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      io_wr_i    <= 1'b1;
      io_addr_i  <= a;
      io_wdata_i <= d;
      @(posedge mclk_i);
      io_wr_i    <= 1'b0;
   endtask : wr

   task automatic rd_port(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk_i);
      io_rd_i   <= 1'b1;
      io_addr_i <= a;
      @(posedge mclk_i);
      io_rd_i   <= 1'b0;
      #1 v = io_rdata_o;
   endtask : rd_port

   task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
      wr(countdown_guard_pkg::INDEX_PORT, idx);
      wr(countdown_guard_pkg::DATA_PORT, d);
   endtask : cfg

   task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] v);
      wr(countdown_guard_pkg::INDEX_PORT, idx);
      rd_port(countdown_guard_pkg::DATA_PORT, v);
   endtask : cfg_rd

   task automatic unlock;
      wr(8'h2e, 8'h87);
      wr(8'h2e, 8'h87);
   endtask : unlock

   // Edges from the call until the request is seen high
   task automatic wait_rise(output int c);
      c = 0;
      while (sys_reset_o !== 1'b1 && c < 2000) begin
         @(posedge mclk_i);
         #1 c++;
      end
   endtask : wait_rise

   task automatic high_len(output int c);
      c = 0;
      while (sys_reset_o === 1'b1 && c < 100) begin
         @(posedge mclk_i);
         #1 c++;
      end
   endtask : high_len

   initial begin
      repeat (6000) @(posedge mclk_i);
      failures++;
      close_out;
   end

   initial begin
      reset_n_i  = 1'b0;
      io_wr_i    = 1'b0;
      io_rd_i    = 1'b0;
      io_addr_i  = 8'h00;
      io_wdata_i = 8'h00;
      repeat (2) @(posedge mclk_i);
      #1 chk8(io_rdata_o, countdown_guard_pkg::LOCKED_READ);
      chk8({7'h00, sys_reset_o}, 8'h00);
      @(posedge mclk_i) reset_n_i <= 1'b1;
      wr(8'h2f, 8'h55);
      rd_port(8'h2f, rd);
      chk8(rd, 8'hff);
      wr(8'h2e, 8'h87);
      wr(8'h2e, 8'h55);
      wr(8'h2e, 8'h87);
      wr(8'h2e, 8'h07);
      rd_port(8'h2f, rd);
      chk8(rd, 8'hff);
      unlock;
      cfg_rd(8'h30, rd);
      chk8(rd, 8'hff);
      foreach (rows[i]) begin
         cfg(rows[i].idx, rows[i].wdata);
         cfg_rd(rows[i].idx, rd);
         chk8(rd, rows[i].exp);
      end
      // The index port reads back the last register selected
      rd_port(8'h2e, rd);
      chk8(rd, 8'h40);
      cfg(8'h30, 8'h01);
      cfg(8'hf1, 8'h02);
      wait_rise(n);
      chkn(n, 2 * N + 1);
      high_len(n);
      chkn(n, 16);
      repeat (3 * N) @(posedge mclk_i);
      chkn(pulses, 16);
      cfg_rd(8'hf1, rd);
      chk8(rd, 8'h00);
      cfg(8'hf1, 8'h03);
      repeat (5) begin
         repeat (2 * N) @(posedge mclk_i);
         cfg(8'hf1, 8'h03);
      end
      chkn(pulses, 16);
      cfg(8'h30, 8'h00);
      repeat (5 * N) @(posedge mclk_i);
      chkn(pulses, 16);
      cfg_rd(8'hf1, rd);
      chk8(rd, 8'h03);
      cfg(8'hf0, 8'h08);
      cfg(8'h30, 8'h01);
      cfg(8'hf1, 8'h01);
      wait_rise(n);
      chkn(n, 60 * N + 1);
      high_len(n);
      chkn(n, 16);
      wr(8'h2e, countdown_guard_pkg::LOCK_KEY);
      rd_port(8'h2f, rd);
      chk8(rd, 8'hff);
      unlock;
      cfg(8'hf1, 8'h02);
      // Leave a non-idle value on the read data so the reset check below can trip
      cfg_rd(8'hf1, rd);
      chk8(rd, 8'h02);
      @(posedge mclk_i) reset_n_i <= 1'b0;
      #1 chk8(io_rdata_o, 8'hff);
      chk8({7'h00, sys_reset_o}, 8'h00);
      @(posedge mclk_i) reset_n_i <= 1'b1;
      unlock;
      cfg_rd(8'h07, rd);
      chk8(rd, countdown_guard_pkg::LDN_RESET);
      // Enable written before the device is selected must be dropped
      cfg(8'h30, 8'h01);
      cfg(8'h07, 8'h08);
      cfg_rd(8'h30, rd);
      chk8(rd, countdown_guard_pkg::ENABLE_RESET);
      cfg_rd(8'hf1, rd);
      chk8(rd, countdown_guard_pkg::COUNT_RESET);
      close_out;
   end

endmodule : system_watchdog_timer_tb

//--- rtl/countdown_guard_pkg.sv
package countdown_guard_pkg;

   // Configuration port addresses on the I/O space
   localparam logic [7:0] INDEX_PORT     = 8'h2e;
   localparam logic [7:0] DATA_PORT      = 8'h2f;

   // Index port keys
   localparam logic [7:0] UNLOCK_KEY     = 8'h87;
   localparam logic [7:0] LOCK_KEY       = 8'haa;

   // Configuration register indexes
   localparam logic [7:0] REG_LDN        = 8'h07;
   localparam logic [7:0] REG_ENABLE     = 8'h30;
   localparam logic [7:0] REG_UNIT       = 8'hf0;
   localparam logic [7:0] REG_PRESET     = 8'hf1;

   // Logical device number of the countdown guard
   localparam logic [7:0] LDN_GUARD      = 8'h08;

   // Field values
   localparam logic [7:0] UNIT_SEC       = 8'h00;
   localparam logic [7:0] UNIT_MIN       = 8'h08;
   localparam int         ENABLE_BIT     = 0;

   // Reset values
   localparam logic [7:0] LDN_RESET      = 8'h00;
   localparam logic [7:0] ENABLE_RESET   = 8'h00;
   localparam logic [7:0] UNIT_RESET     = 8'h00;
   localparam logic [7:0] COUNT_RESET    = 8'h00;
   localparam logic [7:0] INDEX_RESET    = 8'h00;
   localparam logic [7:0] LOCKED_READ    = 8'hff;

   // Timing
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned SEC_MS        = 1000;
   localparam int unsigned SEC_CYCLES    = CLK_HZ / 1000 * SEC_MS;
   localparam int          SEC_CNT_W     = 25;
   localparam logic [5:0]  SECS_PER_MIN  = 6'h3c;
   localparam int          PULSE_CNT_W   = 5;
   localparam logic [4:0]  RESET_PULSE_CYCLES = 5'h10;

   typedef enum logic [1:0] {
      CFG_LOCKED   = 2'b00,
      CFG_KEY_SEEN = 2'b01,
      CFG_OPEN     = 2'b10
   } cfg_state_e;

endpackage : countdown_guard_pkg

//--- rtl/guard_prescaler.sv
module guard_prescaler #(
   parameter int unsigned SEC_CYCLES = countdown_guard_pkg::SEC_CYCLES
) (
   // Clock and reset
   input  wire logic          mclk_i,
   input  wire logic          reset_n_i,
   // Tick carrier
   guard_tick_if.source       tick
);

   logic [countdown_guard_pkg::SEC_CNT_W-1:0] sec_cnt_q;
   logic [5:0]                                min_cnt_q;
   logic                                      sec_tick_q;
   logic                                      min_tick_q;
   logic                                      sec_wrap;

   assign sec_wrap = (sec_cnt_q == countdown_guard_pkg::SEC_CNT_W'(SEC_CYCLES - 1));

   // Restart on every reload so a fresh count gets a full first unit
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sec_cnt_q <= '0;
      end else if (tick.restart || !tick.run || sec_wrap) begin
         sec_cnt_q <= '0;
      end else begin
         sec_cnt_q <= sec_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         min_cnt_q <= '0;
      end else if (tick.restart || !tick.run) begin
         min_cnt_q <= '0;
      end else if (sec_wrap) begin
         if (min_cnt_q == countdown_guard_pkg::SECS_PER_MIN - 6'h01) begin
            min_cnt_q <= '0;
         end else begin
            min_cnt_q <= min_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sec_tick_q <= 1'b0;
         min_tick_q <= 1'b0;
      end else begin
         sec_tick_q <= tick.run && !tick.restart && sec_wrap;
         min_tick_q <= tick.run && !tick.restart && sec_wrap &&
                       (min_cnt_q == countdown_guard_pkg::SECS_PER_MIN - 6'h01);
      end
   end

   assign tick.sec_tick = sec_tick_q;
   assign tick.min_tick = min_tick_q;

endmodule : guard_prescaler

//--- rtl/guard_tick_if.sv
interface guard_tick_if;
   logic run;
   logic restart;
   logic sec_tick;
   logic min_tick;

   modport source (input run, input restart, output sec_tick, output min_tick);
   modport sink   (output run, output restart, input sec_tick, input min_tick);
endinterface : guard_tick_if

//--- rtl/system_watchdog_timer.sv
module system_watchdog_timer #(
   parameter int unsigned SEC_CYCLES = countdown_guard_pkg::SEC_CYCLES
) (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   // Configuration I/O port access
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   input  wire logic [7:0] io_addr_i,
   input  wire logic [7:0] io_wdata_i,
   output logic      [7:0] io_rdata_o,
   // System reset request
   output logic            sys_reset_o
);

   countdown_guard_pkg::cfg_state_e cfg_state_q;
   countdown_guard_pkg::cfg_state_e cfg_state_d;

   logic [7:0]                                  index_q;
   logic [7:0]                                  ldn_q;
   logic [7:0]                                  enable_q;
   logic [7:0]                                  unit_q;
   logic [7:0]                                  count_q;
   logic [7:0]                                  rdata_q;
   logic [7:0]                                  rdata_d;
   logic                                        sys_reset_q;
   logic [countdown_guard_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;

   logic index_wr;
   logic data_wr;
   logic cfg_open;
   logic load;
   logic unit_tick;
   logic running;
   logic fire;

   guard_tick_if tick ();

   guard_prescaler #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_prescaler (
      .mclk_i     (mclk_i),
      .reset_n_i  (reset_n_i),
      .tick       (tick.source)
   );

   // Registers other than the device select belong to device 08 only
   function automatic logic reg_hit(input logic [7:0] idx,
                                    input logic [7:0] reg_idx,
                                    input logic [7:0] ldn);
      reg_hit = (idx == reg_idx) &&
                ((reg_idx == countdown_guard_pkg::REG_LDN) ||
                 (ldn == countdown_guard_pkg::LDN_GUARD));
   endfunction : reg_hit

   assign cfg_open = (cfg_state_q == countdown_guard_pkg::CFG_OPEN);
   assign index_wr = io_wr_i && (io_addr_i == countdown_guard_pkg::INDEX_PORT);
   assign data_wr  = io_wr_i && (io_addr_i == countdown_guard_pkg::DATA_PORT) &&
                     cfg_open;

   // Unlock sequence; any other index write breaks a half-entered key
   always_comb begin
      cfg_state_d = cfg_state_q;
      if (index_wr) begin
         unique case (cfg_state_q)
            countdown_guard_pkg::CFG_LOCKED: begin
               if (io_wdata_i == countdown_guard_pkg::UNLOCK_KEY) begin
                  cfg_state_d = countdown_guard_pkg::CFG_KEY_SEEN;
               end
            end
            countdown_guard_pkg::CFG_KEY_SEEN: begin
               if (io_wdata_i == countdown_guard_pkg::UNLOCK_KEY) begin
                  cfg_state_d = countdown_guard_pkg::CFG_OPEN;
               end else begin
                  cfg_state_d = countdown_guard_pkg::CFG_LOCKED;
               end
            end
            countdown_guard_pkg::CFG_OPEN: begin
               if (io_wdata_i == countdown_guard_pkg::LOCK_KEY) begin
                  cfg_state_d = countdown_guard_pkg::CFG_LOCKED;
               end
            end
            default: begin
               cfg_state_d = countdown_guard_pkg::CFG_LOCKED;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_state_q <= countdown_guard_pkg::CFG_LOCKED;
      end else begin
         cfg_state_q <= cfg_state_d;
      end
   end

   // Index latches only while open, so key bytes never select a register
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         index_q <= countdown_guard_pkg::INDEX_RESET;
      end else if (index_wr && cfg_open && (io_wdata_i != countdown_guard_pkg::LOCK_KEY)) begin
         index_q <= io_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ldn_q <= countdown_guard_pkg::LDN_RESET;
      end else if (data_wr && reg_hit(index_q, countdown_guard_pkg::REG_LDN, ldn_q)) begin
         ldn_q <= io_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enable_q <= countdown_guard_pkg::ENABLE_RESET;
      end else if (data_wr && reg_hit(index_q, countdown_guard_pkg::REG_ENABLE, ldn_q)) begin
         enable_q <= io_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         unit_q <= countdown_guard_pkg::UNIT_RESET;
      end else if (data_wr && reg_hit(index_q, countdown_guard_pkg::REG_UNIT, ldn_q)) begin
         unit_q <= io_wdata_i;
      end
   end

   // Any unit value other than minutes counts seconds
   assign unit_tick = (unit_q == countdown_guard_pkg::UNIT_MIN) ? tick.min_tick
                                                                : tick.sec_tick;

   assign load    = data_wr && reg_hit(index_q, countdown_guard_pkg::REG_PRESET, ldn_q);
   assign running = enable_q[countdown_guard_pkg::ENABLE_BIT] && (count_q != 8'h00);
   assign fire    = running && unit_tick && (count_q == 8'h01) && !load;

   assign tick.run     = running;
   assign tick.restart = load;

   // A reload wins over a tick in the same cycle, which is what keeps a healthy system alive
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_q <= countdown_guard_pkg::COUNT_RESET;
      end else if (load) begin
         count_q <= io_wdata_i;
      end else if (running && unit_tick) begin
         count_q <= count_q - 8'h01;
      end
   end

   // Fixed-width reset pulse so downstream reset logic sees a clean level
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pulse_cnt_q <= '0;
         sys_reset_q <= 1'b0;
      end else if (fire) begin
         pulse_cnt_q <= countdown_guard_pkg::RESET_PULSE_CYCLES - 5'h01;
         sys_reset_q <= 1'b1;
      end else if (pulse_cnt_q != '0) begin
         pulse_cnt_q <= pulse_cnt_q - 5'h01;
      end else begin
         sys_reset_q <= 1'b0;
      end
   end

   assign sys_reset_o = sys_reset_q;

   // Count register reads back the live count, not the last loaded value
   always_comb begin
      rdata_d = countdown_guard_pkg::LOCKED_READ;
      if (cfg_open && (io_addr_i == countdown_guard_pkg::INDEX_PORT)) begin
         rdata_d = index_q;
      end else if (cfg_open && (io_addr_i == countdown_guard_pkg::DATA_PORT)) begin
         if (reg_hit(index_q, countdown_guard_pkg::REG_LDN, ldn_q)) begin
            rdata_d = ldn_q;
         end else if (reg_hit(index_q, countdown_guard_pkg::REG_ENABLE, ldn_q)) begin
            rdata_d = enable_q;
         end else if (reg_hit(index_q, countdown_guard_pkg::REG_UNIT, ldn_q)) begin
            rdata_d = unit_q;
         end else if (reg_hit(index_q, countdown_guard_pkg::REG_PRESET, ldn_q)) begin
            rdata_d = count_q;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q <= countdown_guard_pkg::LOCKED_READ;
      end else if (io_rd_i) begin
         rdata_q <= rdata_d;
      end
   end

   assign io_rdata_o = rdata_q;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);

   property p_unlock;
      (index_wr && io_wdata_i == countdown_guard_pkg::UNLOCK_KEY &&
       cfg_state_q == countdown_guard_pkg::CFG_KEY_SEEN) |=> cfg_open;
   endproperty
   a_unlock: assert property (p_unlock) else $error("double key did not unlock");

   property p_locked_no_write;
      (!cfg_open && io_wr_i && io_addr_i == countdown_guard_pkg::DATA_PORT)
         |=> ($stable(count_q) || $past(running && unit_tick)) && $stable(enable_q);
   endproperty
   a_locked_no_write: assert property (p_locked_no_write)
      else $error("write while locked");

   property p_fire;
      (running && unit_tick && count_q == 8'h01 && !load) |=> sys_reset_o && count_q == 8'h00;
   endproperty
   a_fire: assert property (p_fire) else $error("zero count gave no reset");

   property p_pulse;
      $rose(sys_reset_o) |-> sys_reset_o [*8] ##1 sys_reset_o [*8] ##1 !sys_reset_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse wrong width");

   property p_minutes;
      (unit_q == countdown_guard_pkg::UNIT_MIN && !tick.min_tick && !load) |=> $stable(count_q);
   endproperty
   a_minutes: assert property (p_minutes) else $error("minute unit counted early");

   property p_load;
      load |=> count_q == $past(io_wdata_i);
   endproperty
   a_load: assert property (p_load) else $error("count load lost");

   property p_disabled;
      (!enable_q[countdown_guard_pkg::ENABLE_BIT] && !load)
         |=> $stable(count_q) && !$rose(sys_reset_o);
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled guard counted");

   property p_other_ldn;
      (data_wr && ldn_q != countdown_guard_pkg::LDN_GUARD &&
       index_q == countdown_guard_pkg::REG_ENABLE) |=> $stable(enable_q);
   endproperty
   a_other_ldn: assert property (p_other_ldn)
      else $error("enable written off device");

endmodule : system_watchdog_timer
